/* File: core/wwd_consts.svh */
// Constants of the window watchdog: offsets, fields, reset values and timing
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH

// ----------------------------------------
// Register offsets on the die link
// ----------------------------------------
`define WWD_CONFIG_OFS 8'h00
`define WWD_SERVICE_OFS 8'h01

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WWD_DISABLED_BIT 7
`define WWD_WINDOW_OPEN_BIT 6
`define WWD_TSEL_MSB 2
`define WWD_TSEL_LSB 0

// ----------------------------------------
// Reset values and service codes
// ----------------------------------------
`define WWD_TSEL_RESET 3'h0
`define WWD_SERVICE_RESET 8'h00
`define WWD_CODE_FIRST 8'hAA
`define WWD_CODE_SECOND 8'h55

// ----------------------------------------
// Timing
// ----------------------------------------
`define WWD_CLK_KHZ 25000
`define WWD_UNIT_MS 10
`define WWD_INIT_MS 200
`define WWD_UNIT_CYCLES (`WWD_UNIT_MS * `WWD_CLK_KHZ)
`define WWD_INIT_CYCLES (`WWD_INIT_MS * `WWD_CLK_KHZ)
`define WWD_CNT_W 26

`endif

/* File: core/wwd_limit.sv */
// Window timeout length and half-window point from the timeout select
`timescale 1ns/1ps
`include "wwd_consts.svh"
module wwd_limit #(
    parameter wwd_pkg::wwd_cnt_t UNIT_CYCLES = wwd_pkg::wwd_cnt_t'(`WWD_UNIT_CYCLES)
) (
    input wire wwd_pkg::wwd_tsel_t tsel, // Timeout select code
    output wwd_pkg::wwd_cnt_t limit, // Full timeout in cycles
    output wwd_pkg::wwd_cnt_t half // First half of the timeout
);
    import wwd_pkg::*;

    // Code n gives the base unit doubled n times
    assign limit = UNIT_CYCLES << tsel;
    assign half = limit >> 1;
endmodule

/* File: core/wwd_pkg.sv */
// Types shared by the window watchdog modules
package wwd_pkg;
    typedef logic [7:0] wwd_byte_t;
    typedef logic [2:0] wwd_tsel_t;
    typedef logic [25:0] wwd_cnt_t;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_INIT = 2'b01,
        ST_WINDOW = 2'b10
    } wwd_state_t;
endpackage

/* File: core/wwd_sync.sv */
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module wwd_sync (
    input wire logic clk, // Base clock
    input wire logic rst, // Synchronous reset, high
    input wire logic din, // Asynchronous level
    output logic dout // Synchronised level
);
    logic meta;

    // Only the second flop reads the first
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

/* File: core/wwd_top.sv */
// Window watchdog with its configuration and service registers
`timescale 1ns/1ps
`include "wwd_consts.svh"

// Notes on behaviour
// - Runs only in Normal mode, on its own base clock.
// - Timeout select bits 2..0 give 10 ms doubling up to 1280 ms.
// - Inactive in low power; a read in Stop shows the disabled flag set.
// - After reset a fixed initial timeout runs, window flag set, config writable.
// - Initial phase: timeout or any non-0xAA service write causes reset.
// - Window mode refuses service in first half; service due in second half.
// - Bit 6 reads whether the service window is open now.
// - Window mode: timeout or wrong service value forces a watchdog reset.
// - Test-pin disable stops the watchdog; bit 7 reads disabled.
// - Disabling restores the service register; re-enable restarts initial sequence.
// - Service writes while disabled are ignored.
// - Low power halts the watchdog and restores the service register.
module wwd_top #(
    parameter wwd_pkg::wwd_cnt_t UNIT_CYCLES = wwd_pkg::wwd_cnt_t'(`WWD_UNIT_CYCLES),
    parameter wwd_pkg::wwd_cnt_t INIT_CYCLES = wwd_pkg::wwd_cnt_t'(`WWD_INIT_CYCLES)
) (
    input wire logic CLK, // Base clock, 25 MHz
    input wire logic SYS_RST, // Analog reset, synchronous, high
    input wire logic NORMAL_MODE, // High in Normal mode, low in low power
    input wire logic TEST_DISABLE, // Test-pin disable condition, async
    input wire wwd_pkg::wwd_byte_t REG_ADDR, // Register offset
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    input wire wwd_pkg::wwd_byte_t REG_WDATA, // Write data
    output wwd_pkg::wwd_byte_t REG_RDATA, // Read data, registered
    output logic WDG_RESET, // Watchdog reset pulse
    output logic WDG_DISABLED // Watchdog disabled level
);
    import wwd_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wwd_state_t state;
    wwd_state_t next_state;
    wwd_cnt_t cnt;
    wwd_cnt_t next_cnt;
    wwd_cnt_t win_limit;
    wwd_cnt_t win_half;
    wwd_tsel_t tsel;
    wwd_byte_t service;
    wwd_byte_t expect_val;
    wwd_byte_t cfg_read;
    logic expect_first;
    logic next_expect_first;
    logic next_fire;
    logic test_dis_s;
    logic enabled;
    logic cfg_wr;
    logic svc_wr;
    logic win_open;
    logic window_open_flag;

    // ----------------------------------------
    // Input crossing and enables
    // ----------------------------------------
    wwd_sync u_test_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .din(TEST_DISABLE),
        .dout(test_dis_s)
    );

    assign enabled = NORMAL_MODE && !test_dis_s;
    assign cfg_wr = REG_WR && (REG_ADDR == `WWD_CONFIG_OFS);
    assign svc_wr = REG_WR && (REG_ADDR == `WWD_SERVICE_OFS);

    // ----------------------------------------
    // Timeout length
    // ----------------------------------------
    wwd_limit #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_limit (
        .tsel(tsel),
        .limit(win_limit),
        .half(win_half)
    );

    assign win_open = (cnt >= win_half);
    // Flag set throughout the initial phase
    assign window_open_flag = (state == ST_INIT) || ((state == ST_WINDOW) && win_open);
    assign expect_val = expect_first ? `WWD_CODE_FIRST : `WWD_CODE_SECOND;

    // ----------------------------------------
    // Watchdog sequence
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt + wwd_cnt_t'(1);
        next_expect_first = expect_first;
        next_fire = 1'b0;
        if (!enabled) begin
            next_state = ST_OFF;
            next_cnt = '0;
            next_expect_first = 1'b1;
        end else begin
            unique case (state)
                ST_OFF: begin
                    next_state = ST_INIT;
                    next_cnt = '0;
                    next_expect_first = 1'b1;
                end
                ST_INIT: begin
                    if (svc_wr) begin
                        if (REG_WDATA == `WWD_CODE_FIRST) begin
                            next_state = ST_WINDOW;
                            next_cnt = '0;
                            next_expect_first = 1'b0;
                        end else begin
                            next_fire = 1'b1;
                        end
                    end else if (cnt == INIT_CYCLES - wwd_cnt_t'(1)) begin
                        next_fire = 1'b1;
                    end
                end
                ST_WINDOW: begin
                    if (svc_wr) begin
                        // Early service is refused and trips
                        if (win_open && (REG_WDATA == expect_val)) begin
                            next_cnt = '0;
                            next_expect_first = !expect_first;
                        end else begin
                            next_fire = 1'b1;
                        end
                    end else if (cnt == win_limit - wwd_cnt_t'(1)) begin
                        next_fire = 1'b1;
                    end
                end
                default: begin
                    next_state = ST_OFF;
                    next_cnt = '0;
                end
            endcase
            // A trip starts the device over from the initial phase
            if (next_fire) begin
                next_state = ST_INIT;
                next_cnt = '0;
                next_expect_first = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= ST_OFF;
            cnt <= '0;
            expect_first <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            expect_first <= next_expect_first;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WDG_RESET <= 1'b0;
        end else begin
            WDG_RESET <= next_fire;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Timeout select
    // Writable anytime; initial phase ignores it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tsel <= `WWD_TSEL_RESET;
        end else if (cfg_wr) begin
            tsel <= REG_WDATA[`WWD_TSEL_MSB:`WWD_TSEL_LSB];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            service <= `WWD_SERVICE_RESET;
        end else if (!enabled) begin
            service <= `WWD_SERVICE_RESET;
        end else if (svc_wr) begin
            service <= REG_WDATA;
        end
    end

    always_comb begin
        cfg_read = 8'h00;
        // Disabled flag set in low power
        cfg_read[`WWD_DISABLED_BIT] = !enabled;
        cfg_read[`WWD_WINDOW_OPEN_BIT] = window_open_flag;
        cfg_read[`WWD_TSEL_MSB:`WWD_TSEL_LSB] = tsel;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            if (REG_ADDR == `WWD_CONFIG_OFS) begin
                REG_RDATA <= cfg_read;
            end else if (REG_ADDR == `WWD_SERVICE_OFS) begin
                REG_RDATA <= service;
            end else begin
                REG_RDATA <= 8'h00;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WDG_DISABLED <= 1'b0;
        end else begin
            WDG_DISABLED <= !enabled;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_enter_window;
        (state == ST_INIT) && enabled && svc_wr && (REG_WDATA == `WWD_CODE_FIRST);
    endsequence

    sequence s_counting_restart;
        (state == ST_WINDOW) && (cnt == '0) && !expect_first;
    endsequence

    a_init_entry: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_enter_window |=> s_counting_restart)
        else $error("0xAA in initial phase did not enter window mode");

    a_init_bad_code: assert property (@(posedge CLK) disable iff (SYS_RST)
        ((state == ST_INIT) && enabled && svc_wr && (REG_WDATA != `WWD_CODE_FIRST)) |=> WDG_RESET)
        else $error("Wrong initial service code did not reset");

    a_init_timeout: assert property (@(posedge CLK) disable iff (SYS_RST)
        ((state == ST_INIT) && enabled && !svc_wr && (cnt == INIT_CYCLES - wwd_cnt_t'(1))) |=> WDG_RESET)
        else $error("Initial timeout did not reset");

    a_early_service: assert property (@(posedge CLK) disable iff (SYS_RST)
        ((state == ST_WINDOW) && enabled && svc_wr && (cnt < win_half)) |=> (WDG_RESET && state == ST_INIT))
        else $error("Service in closed window was not refused");

    a_window_timeout: assert property (@(posedge CLK) disable iff (SYS_RST)
        ((state == ST_WINDOW) && enabled && !svc_wr && (cnt == win_limit - wwd_cnt_t'(1))) |=> WDG_RESET)
        else $error("Window timeout did not reset");

    a_good_service: assert property (@(posedge CLK) disable iff (SYS_RST)
        ((state == ST_WINDOW) && enabled && svc_wr && win_open && (REG_WDATA == expect_val))
        |=> ((cnt == '0) && !WDG_RESET && (expect_first != $past(expect_first))))
        else $error("Valid service did not restart the count");

    a_open_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
        (REG_RD && (REG_ADDR == `WWD_CONFIG_OFS)) |=> (REG_RDATA[6] == $past(window_open_flag)))
        else $error("Window open flag read wrong");

    a_disabled_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        (REG_RD && (REG_ADDR == `WWD_CONFIG_OFS) && !NORMAL_MODE) |=> REG_RDATA[7])
        else $error("Disabled flag clear during low power read");

    a_disabled_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!enabled ##1 !enabled) |-> (!WDG_RESET && (state == ST_OFF) && (service == `WWD_SERVICE_RESET)))
        else $error("Disabled watchdog not idle");

    a_reenable_init: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!SYS_RST && (state == ST_OFF) && enabled) |=> ((state == ST_INIT) && (cnt == '0) && expect_first))
        else $error("Re-enable did not restart initial phase");

    a_disabled_pin: assert property (@(posedge CLK) disable iff (SYS_RST)
        !SYS_RST |=> (WDG_DISABLED == !$past(enabled)))
        else $error("Disabled output does not follow enable");

    a_disabled_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!enabled && svc_wr) |=> (!WDG_RESET && (service == `WWD_SERVICE_RESET)))
        else $error("Service write while disabled took effect");

    a_tsel_store: assert property (@(posedge CLK) disable iff (SYS_RST)
        cfg_wr |=> (tsel == $past(REG_WDATA[`WWD_TSEL_MSB:`WWD_TSEL_LSB])))
        else $error("Timeout select not stored");

    a_low_power_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        !NORMAL_MODE |=> ((state == ST_OFF) && (cnt == '0) && (service == `WWD_SERVICE_RESET)))
        else $error("Low power did not halt the watchdog");
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the window watchdog
`timescale 1ns/1ps
`include "wwd_consts.svh"
module tb;
    import wwd_pkg::*;
    localparam int UNIT = 16;
    localparam int INIT = 40;
    logic clk = 1'b0;
    logic sys_rst;
    logic normal_mode;
    logic test_disable;
    wwd_byte_t reg_addr;
    logic reg_wr;
    logic reg_rd;
    wwd_byte_t reg_wdata;
    wwd_byte_t reg_rdata;
    logic wdg_reset;
    logic wdg_disabled;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_rst = 0;
    int rel;
    int n;
    int k0;
    wwd_byte_t d;

    always #20 clk = ~clk;

    wwd_top #(.UNIT_CYCLES(wwd_cnt_t'(UNIT)), .INIT_CYCLES(wwd_cnt_t'(INIT))) u_dut (
        .CLK(clk), .SYS_RST(sys_rst), .NORMAL_MODE(normal_mode), .TEST_DISABLE(test_disable),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .WDG_RESET(wdg_reset), .WDG_DISABLED(wdg_disabled));

    wwd_sw_model u_sw (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // Pulses are counted here so none is missed while a task is busy
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wdg_reset === 1'b1) begin
            n_rst <= n_rst + 1;
        end
        if (cyc > 50000) begin
            err_count = err_count + 1;
            finish_test();
        end
    end

    task automatic check(input string name, input wwd_byte_t seen, input wwd_byte_t exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Waits for the next reset pulse; an exhausted bound ends the run
    task automatic wait_rst(input int max, output int cnt);
        int k;
        k = n_rst;
        cnt = 0;
        while (n_rst == k && cnt < max) begin
            @(posedge clk);
            #1;
            cnt = cnt + 1;
        end
        if (n_rst == k) begin
            check("reset pulse", 8'h00, 8'h01);
            finish_test();
        end
    endtask

    task automatic in_range(input string name, input int v, input int lo, input int hi);
        check(name, {7'h00, (v >= lo && v <= hi)}, 8'h01);
    endtask

    initial begin
        sys_rst = 1'b1;
        normal_mode = 1'b1;
        test_disable = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rel = cyc;
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("config after reset", d, 8'h40);
        u_sw.rd(8'h05, d);
        check("unmapped read", d, 8'h00);
        // Longest window select must not stretch the initial timeout
        u_sw.wr(`WWD_CONFIG_OFS, 8'h07);
        wait_rst(INIT + 20, n);
        in_range("initial timeout", cyc - rel, INIT - 1, INIT + 3);
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("config kept", d, 8'h47);
        u_sw.wr(`WWD_SERVICE_OFS, 8'h12);
        wait_rst(6, n);
        for (int k = 0; k < 8; k++) begin
            u_sw.wr(`WWD_CONFIG_OFS, k[7:0]);
            u_sw.wr(`WWD_SERVICE_OFS, 8'hAA);
            wait_rst(3000, n);
            in_range("window timeout", n, (UNIT << k) - 1, (UNIT << k) + 2);
        end
        // Limit 32, half 16
        u_sw.wr(`WWD_CONFIG_OFS, 8'h01);
        u_sw.wr(`WWD_SERVICE_OFS, 8'hAA);
        k0 = n_rst;
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("window closed", d, 8'h01);
        repeat (16) @(posedge clk);
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("window open", d, 8'h41);
        u_sw.wr(`WWD_SERVICE_OFS, 8'h55);
        u_sw.rd(`WWD_SERVICE_OFS, d);
        check("service readback", d, 8'h55);
        repeat (17) @(posedge clk);
        u_sw.wr(`WWD_SERVICE_OFS, 8'hAA);
        repeat (18) @(posedge clk);
        check("no reset on service", n_rst[7:0] - k0[7:0], 8'h00);
        u_sw.wr(`WWD_SERVICE_OFS, 8'hAA);
        wait_rst(6, n);
        u_sw.wr(`WWD_SERVICE_OFS, 8'hAA);
        u_sw.wr(`WWD_SERVICE_OFS, 8'h55);
        wait_rst(6, n);
        // Test-pin disable, driven on the edge
        @(posedge clk);
        test_disable <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check("disabled pin", {7'h00, wdg_disabled}, 8'h01);
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("disabled flag", d & 8'h87, 8'h81);
        k0 = n_rst;
        u_sw.wr(`WWD_SERVICE_OFS, 8'h12);
        u_sw.rd(`WWD_SERVICE_OFS, d);
        check("service default", d, 8'h00);
        repeat (INIT + 20) @(posedge clk);
        check("no reset disabled", n_rst[7:0] - k0[7:0], 8'h00);
        test_disable <= 1'b0;
        repeat (4) @(posedge clk);
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("re-enabled", d, 8'h41);
        // Low power mode
        u_sw.wr(`WWD_SERVICE_OFS, 8'hAA);
        normal_mode <= 1'b0;
        k0 = n_rst;
        repeat (2) @(posedge clk);
        u_sw.rd(`WWD_CONFIG_OFS, d);
        check("low power flag", d & 8'h87, 8'h81);
        u_sw.rd(`WWD_SERVICE_OFS, d);
        check("low power service", d, 8'h00);
        repeat (INIT + 20) @(posedge clk);
        check("no reset low power", n_rst[7:0] - k0[7:0], 8'h00);
        normal_mode <= 1'b1;
        wait_rst(INIT + 10, n);
        in_range("restart initial", n, INIT - 1, INIT + 4);
        finish_test();
    end
endmodule

/* File: testbench/wwd_sw_model.sv */
// Software-side model driving the die link register port
`timescale 1ns/1ps
module wwd_sw_model (
    input wire logic clk, // Base clock
    output wwd_pkg::wwd_byte_t reg_addr, // Register offset
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output wwd_pkg::wwd_byte_t reg_wdata, // Write data
    input wire wwd_pkg::wwd_byte_t reg_rdata // Read data
);
    import wwd_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Data is inverted after a write so a stale value is never mistaken for valid
    task automatic wr(input wwd_byte_t a, input wwd_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input wwd_byte_t a, output wwd_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule
